// ### dv/spitrp_host_model.sv
// Host controller model: drives select, serial clock and data in, captures data out.
// Assumes the bench ref_clk; every pin change lands 1 ns after a ref_clk rise.
`timescale 1ns/1ps
module spitrp_host_model (
    input wire logic ref_clk,
    input wire logic sdo,
    output logic sel_n,
    output logic sclk,
    output logic sdi
);
    localparam int HALF = 10; // Half of the 80 ns serial period

    // Deselected with the clock parked high
    initial begin
        sel_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_clk

    // Clock and data toggle while deselected; the device must not react
    task automatic idle_toggle(input int n);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            sdi = ~sdi;
            wait_clk(HALF);
            sclk = 1'b1;
            wait_clk(HALF);
        end
    endtask : idle_toggle

    // One frame of 16 + nd bits; a negative nd cuts the header short.
    // The clock may pause low at bit stall, far longer than a bit time.
    task automatic xfer(input logic wr, input logic [14:0] addr, input logic [31:0] wd,
                        input int nd, input int stall, output logic [31:0] rd,
                        output logic [14:0] echo);
        logic [15:0] hdr;
        hdr = {wr, addr}; // Direction first, address MSB first
        rd = '0;
        echo = '0;
        wait_clk(1);
        sel_n = 1'b0;
        wait_clk(HALF);
        for (int i = 0; i < 16 + nd; i++) begin
            sclk = 1'b0; // Host output changes on the fall
            sdi = (i < 16) ? hdr[15 - i] : wd[31 - (i - 16)];
            wait_clk(HALF);
            if (i == stall) wait_clk(300);
            sclk = 1'b1; // Both ends sample on the rise, one bit each way
            if (i >= 1 && i < 16) echo = {echo[13:0], sdo};
            if (i >= 16) rd[31 - (i - 16)] = sdo;
            wait_clk(HALF);
        end
        // Clock already stopped high, then deselect; released line flips
        sel_n = 1'b1;
        sdi = ~sdi;
        wait_clk(HALF);
    endtask : xfer
endmodule : spitrp_host_model

// ### dv/spitrp_top_tb.sv
// Self-checking bench for the serial target register port.
// Assumes the host model above drives every serial input pin of the design.
`timescale 1ns/1ps
module spitrp_top_tb;
    logic ref_clk;
    logic nrst;
    logic sel_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic busy;
    logic [31:0] rd;
    logic [14:0] echo;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    spitrp_top i_spitrp_top (.ref_clk(ref_clk), .nrst(nrst), .sel_n(sel_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy));
    spitrp_host_model i_spitrp_host_model (.ref_clk(ref_clk), .sdo(sdo), .sel_n(sel_n),
        .sclk(sclk), .sdi(sdi));

    ////////////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Hang guard: the whole run needs about 7.6k cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////////
    // Reset values, then deselected traffic must leave the frame logic idle
    task automatic t_reset_ignore();
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("sdo_oe in reset", 32'h0, sdo_oe);
        check("busy in reset", 32'h0, busy);
        nrst = 1'b1;
        i_spitrp_host_model.idle_toggle(9);
        check("busy deselected", 32'h0, busy);
        check("sdo_oe deselected", 32'h0, sdo_oe);
    endtask : t_reset_ignore

    // Two-byte write across the top of RAM, four-byte read through revision and status
    task automatic t_burst();
        i_spitrp_host_model.xfer(1'b1, 15'h001e, 32'ha53c0000, 16, -1, rd, echo);
        check("write echo", 32'h0000001e, echo);
        i_spitrp_host_model.xfer(1'b0, 15'h001e, 32'h0, 32, -1, rd, echo);
        check("read echo", 32'h0000001e, echo);
        check("burst read", 32'ha53c1101, rd);
        check("busy after frame", 32'h0, busy);
    endtask : t_burst

    // Writes to read-only and unused places change only the status, which then reports them refused
    task automatic t_refused();
        i_spitrp_host_model.xfer(1'b1, 15'h0020, 32'h5a000000, 8, -1, rd, echo);
        i_spitrp_host_model.xfer(1'b1, 15'h0100, 32'h77000000, 8, -1, rd, echo);
        i_spitrp_host_model.xfer(1'b0, 15'h0021, 32'h0, 8, -1, rd, echo);
        check("status refused", 32'h02000000, rd);
        i_spitrp_host_model.xfer(1'b0, 15'h0020, 32'h0, 8, -1, rd, echo);
        check("revision kept", 32'h11000000, rd);
        i_spitrp_host_model.xfer(1'b0, 15'h0100, 32'h0, 8, -1, rd, echo);
        check("unused reads zero", 32'h0, rd);
        i_spitrp_host_model.xfer(1'b0, 15'h0000, 32'h0, 8, -1, rd, echo);
        check("no alias write", 32'h0, rd);
    endtask : t_refused

    // Deselect mid-header and mid-byte, then a fresh read must frame correctly
    task automatic t_abort();
        i_spitrp_host_model.xfer(1'b1, 15'h0005, 32'h0, -8, -1, rd, echo);
        check("busy after abort", 32'h0, busy);
        i_spitrp_host_model.xfer(1'b1, 15'h0005, 32'hff000000, 5, -1, rd, echo);
        i_spitrp_host_model.xfer(1'b0, 15'h0005, 32'h0, 8, -1, rd, echo);
        check("aborted write", 32'h0, rd);
    endtask : t_abort

    // Clock pauses in the data phase of a write and the address phase of a read
    task automatic t_stall();
        // Mid-stall look: the frame must still be open and driving
        fork
            i_spitrp_host_model.xfer(1'b1, 15'h0007, 32'hc3000000, 8, 20, rd, echo);
            begin
                repeat (550) @(posedge ref_clk);
                #1;
                check("busy in stall", 32'h1, busy);
                check("sdo_oe in frame", 32'h1, sdo_oe);
            end
        join
        i_spitrp_host_model.xfer(1'b0, 15'h0007, 32'h0, 8, 10, rd, echo);
        check("stalled read", 32'hc3000000, rd);
        check("stalled echo", 32'h00000007, echo);
    endtask : t_stall

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        t_reset_ignore();
        t_burst();
        t_refused();
        t_abort();
        t_stall();
        results();
    end
endmodule : spitrp_top_tb

// ### shared/spitrp_pkg.sv
// Package for the serial target register port: frame layout, map sizes, carriers.
// Assumes one ref_clk domain; serial pins are sampled, never used as clocks.
package spitrp_pkg;
    // Frame layout
    localparam int unsigned ADDR_W = 15;
    localparam int unsigned DATA_W = 8;
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [4:0] ADDR_LAST = 5'h0f; // Direction bit plus 15 address bits
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Register map: writable block at the bottom, read-only status above it
    localparam int unsigned RAM_AW = 5;
    localparam logic [14:0] RAM_TOP = 15'h001f;
    localparam logic [14:0] REV_ADDR = 15'h0020;
    localparam logic [14:0] STAT_ADDR = 15'h0021;
    localparam logic [7:0] REV_VALUE = 8'h11; // Arbitrary design revision value
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [14:0] ADDR_RST = 15'h0000;

    typedef enum logic [1:0] {
        SPITRP_ST_CMD = 2'b00,
        SPITRP_ST_WR = 2'b01,
        SPITRP_ST_RD = 2'b10
    } spitrp_state_t;

    // One write request into the register store
    typedef struct packed {
        logic en;
        logic [14:0] addr;
        logic [7:0] data;
    } spitrp_wreq_t;
endpackage : spitrp_pkg

// ### src/spitrp_regmem.sv
// Small register store: 32 writable bytes with registered read data.
// Assumes address is already decoded to the writable range by the caller.
`timescale 1ns/1ps
module spitrp_regmem (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem_ff [0:31];
    logic [7:0] rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Writes land on the edge; read data is registered, so one cycle latency
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            for (int i = 0; i < 32; i++) begin
                mem_ff[i] <= spitrp_pkg::DATA_RST;
            end
            rdata_ff <= spitrp_pkg::DATA_RST;
        end else begin
            if (we) begin
                mem_ff[waddr] <= wdata;
            end
            rdata_ff <= mem_ff[raddr];
        end
    end
    assign rdata = rdata_ff;
endmodule : spitrp_regmem

// ### src/spitrp_sync.sv
// Two-flop synchroniser for one level from outside the ref_clk domain.
// Assumes the source is asynchronous; the output is safe to decode.
`timescale 1ns/1ps
module spitrp_sync (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rst_val,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic meta_ff;
        logic out_ff;
    } spitrp_sync_t;
    spitrp_sync_t st_ff;
    spitrp_sync_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Next value: first stage feeds only the second
    always_comb begin
        nxt_st.meta_ff = din;
        nxt_st.out_ff = st_ff.meta_ff;
    end

    // Reset constant is a tie-off at instantiation, never a live signal
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff <= {rst_val, rst_val};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign dout = st_ff.out_ff;
endmodule : spitrp_sync

// ### src/spitrp_top.sv
// Serial target register port, mode 3, 15-bit address, 8-bit data, auto-increment.
// Assumes ref_clk is much faster than the serial clock (at least 8x) so edges are seen.
// Behaviour
// - Sample input on serial clock rise, change output on serial clock fall.
// - After select falls, take the command bits from the serial input.
// - Ignore serial clock and input while select is high.
// - Select rising ends the transfer and clears counter and command state.
// - Echo each received address bit on the serial output.
// - Abort mid-frame on select high, leaving registers unchanged.
// - Tolerate the serial clock stopping indefinitely inside a frame.
// - Each serial clock cycle moves one bit each way.
// - Writable registers read back; read-only revision and status exist.
// - Unused locations read zero.
// - Writes to unused or read-only locations change nothing; the code still records each one as refused in status bit1.
// - Further write bytes go to incremented addresses.
// - Fetch after last address bit; first data bit on next falling edge.
// - Continued clocking on read increments address and shifts next bytes.
`timescale 1ns/1ps
module spitrp_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic busy
);
    typedef struct packed {
        spitrp_pkg::spitrp_state_t state;
        logic sclk_d;
        logic [4:0] cnt;
        logic is_wr;
        logic [14:0] addr;
        logic [7:0] shreg;
        logic sdo_bit;
        logic fetch;
        logic fetch_d;
        spitrp_pkg::spitrp_wreq_t wreq;
        logic [7:0] status;
    } spitrp_st_t;

    spitrp_st_t st_ff;
    spitrp_st_t nxt_st;
    logic sel_n_s;
    logic sclk_s;
    logic sdi_s;
    logic [7:0] mem_rdata;
    logic [7:0] rd_byte;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_in_ram;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; serial clock parks high, select idles high
    spitrp_sync u_sync_sel (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rst_val(1'b1),
        .din(sel_n),
        .dout(sel_n_s)
    );
    spitrp_sync u_sync_clk (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rst_val(1'b1),
        .din(sclk),
        .dout(sclk_s)
    );
    spitrp_sync u_sync_sdi (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rst_val(1'b0),
        .din(sdi),
        .dout(sdi_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register store; only the writable range is ever written
    assign wr_in_ram = st_ff.wreq.en && (st_ff.wreq.addr <= spitrp_pkg::RAM_TOP);
    spitrp_regmem u_mem (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .we(wr_in_ram),
        .waddr(st_ff.wreq.addr[4:0]),
        .wdata(st_ff.wreq.data),
        .raddr(st_ff.addr[4:0]),
        .rdata(mem_rdata)
    );

    // Read mux: store, revision, live status, else zero
    // Status is read live, so a read right after a write reports that write
    always_comb begin
        if (st_ff.addr <= spitrp_pkg::RAM_TOP) begin
            rd_byte = mem_rdata;
        end else if (st_ff.addr == spitrp_pkg::REV_ADDR) begin
            rd_byte = spitrp_pkg::REV_VALUE;
        end else if (st_ff.addr == spitrp_pkg::STAT_ADDR) begin
            rd_byte = st_ff.status;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Edge finders work only on synchronised copies
    // Both are gated by select, so a deselected clock can move nothing
    assign sclk_rise = !sel_n_s && sclk_s && !st_ff.sclk_d;
    assign sclk_fall = !sel_n_s && !sclk_s && st_ff.sclk_d;

    ////////////////////////////////////////////////////////////////////////
    // Frame engine. Apart from the fetch load, nothing happens without an edge, so a stalled
    // clock simply holds every other field where it is.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclk_d = sclk_s;
        nxt_st.wreq.en = 1'b0;
        // Fetch strobe trails its request by one cycle so the store's
        // registered read data has settled when the shift register loads it
        nxt_st.fetch = st_ff.fetch_d;
        nxt_st.fetch_d = 1'b0;
        if (sel_n_s) begin
            // Deselect clears the frame; a half-received byte is dropped
            nxt_st.state = spitrp_pkg::SPITRP_ST_CMD;
            nxt_st.cnt = spitrp_pkg::CNT_RST;
            nxt_st.is_wr = 1'b0;
            nxt_st.sdo_bit = 1'b0;
        end else begin
            case (st_ff.state)
                spitrp_pkg::SPITRP_ST_CMD: begin
                    if (sclk_rise) begin
                        nxt_st.cnt = st_ff.cnt + 5'h01;
                        if (st_ff.cnt == spitrp_pkg::CNT_RST) begin
                            nxt_st.is_wr = sdi_s;
                        end else begin
                            nxt_st.addr = {st_ff.addr[13:0], sdi_s};
                        end
                        if (st_ff.cnt == spitrp_pkg::ADDR_LAST) begin
                            nxt_st.cnt = spitrp_pkg::CNT_RST;
                            nxt_st.fetch_d = !st_ff.is_wr;
                            nxt_st.state = st_ff.is_wr ? spitrp_pkg::SPITRP_ST_WR
                                                       : spitrp_pkg::SPITRP_ST_RD;
                        end
                    end
                    if (sclk_fall) begin
                        nxt_st.sdo_bit = sdi_s;
                    end
                end
                spitrp_pkg::SPITRP_ST_WR: begin
                    if (sclk_rise) begin
                        nxt_st.shreg = {st_ff.shreg[6:0], sdi_s};
                        nxt_st.cnt = st_ff.cnt + 5'h01;
                        if (st_ff.cnt[2:0] == spitrp_pkg::BIT_LAST) begin
                            nxt_st.cnt = spitrp_pkg::CNT_RST;
                            nxt_st.wreq.en = 1'b1;
                            nxt_st.wreq.addr = st_ff.addr;
                            nxt_st.wreq.data = {st_ff.shreg[6:0], sdi_s};
                            nxt_st.addr = st_ff.addr + 15'h0001;
                        end
                    end
                    if (sclk_fall) begin
                        nxt_st.sdo_bit = 1'b0;
                    end
                end
                spitrp_pkg::SPITRP_ST_RD: begin
                    // Fetched byte is taken two cycles after the address settles
                    if (st_ff.fetch) begin
                        nxt_st.shreg = rd_byte;
                    end
                    if (sclk_fall) begin
                        nxt_st.sdo_bit = st_ff.shreg[7];
                        nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
                        nxt_st.cnt = st_ff.cnt + 5'h01;
                        if (st_ff.cnt[2:0] == spitrp_pkg::BIT_LAST) begin
                            nxt_st.cnt = spitrp_pkg::CNT_RST;
                            nxt_st.addr = st_ff.addr + 15'h0001;
                            nxt_st.fetch_d = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_st.state = spitrp_pkg::SPITRP_ST_CMD;
                end
            endcase
        end
        // Status: bit0 last write hit, bit1 last write refused
        if (st_ff.wreq.en) begin
            nxt_st.status = {6'h00, !wr_in_ram, wr_in_ram};
        end
    end

    // State register; sclk_d resets high so a parked clock shows no false edge
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff <= '{state: spitrp_pkg::SPITRP_ST_CMD, sclk_d: 1'b1,
                       cnt: spitrp_pkg::CNT_RST, is_wr: 1'b0,
                       addr: spitrp_pkg::ADDR_RST, shreg: spitrp_pkg::DATA_RST,
                       sdo_bit: 1'b0, fetch: 1'b0, fetch_d: 1'b0,
                       wreq: '{en: 1'b0, addr: spitrp_pkg::ADDR_RST,
                               data: spitrp_pkg::DATA_RST},
                       status: spitrp_pkg::DATA_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: data line driven only while selected
    assign sdo = st_ff.sdo_bit;
    assign sdo_oe = !sel_n_s;
    assign busy = (st_ff.state != spitrp_pkg::SPITRP_ST_CMD) || (st_ff.cnt != 5'h00);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    deselect_clears_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_n_s |=> (st_ff.state == spitrp_pkg::SPITRP_ST_CMD) && (st_ff.cnt == 5'h00))
        else $error("frame state not cleared on deselect");
    idle_ignores_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_n_s |=> !st_ff.wreq.en && $stable(st_ff.addr) && $stable(st_ff.shreg))
        else $error("activity while deselected");
    abort_nowrite_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_n_s |=> !st_ff.wreq.en)
        else $error("write issued after abort");
    echo_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_fall && st_ff.state == spitrp_pkg::SPITRP_ST_CMD |=> sdo == $past(sdi_s))
        else $error("address bit not echoed");
    stall_holds_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !sel_n_s && !sclk_rise && !sclk_fall && !st_ff.fetch |=> $stable(st_ff.cnt))
        else $error("counter moved without clock edge");
    write_incr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        st_ff.wreq.en |-> st_ff.addr == st_ff.wreq.addr + 15'h0001)
        else $error("write address not incremented");
    unused_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        st_ff.addr > spitrp_pkg::STAT_ADDR |-> rd_byte == 8'h00)
        else $error("unused location not zero");
    ro_nowrite_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        st_ff.wreq.en && st_ff.wreq.addr > spitrp_pkg::RAM_TOP
        |-> !wr_in_ram ##1 st_ff.status == 8'h02)
        else $error("write reached read-only space");
    rd_fetch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_rise && st_ff.state == spitrp_pkg::SPITRP_ST_CMD && !st_ff.is_wr
        && st_ff.cnt == spitrp_pkg::ADDR_LAST |=> ##1 st_ff.fetch)
        else $error("read fetch not launched");

    ////////////////////////////////////////////////////////////////////////
    // Data path checks; each comment names the behaviour that it judges
    // Serial output only moves on a falling clock or on deselect
    out_on_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !sclk_fall && !sel_n_s |=> $stable(sdo))
        else $error("serial output moved off a falling edge");
    // Counter steps once per rising clock while the header arrives
    hdr_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_rise && st_ff.state == spitrp_pkg::SPITRP_ST_CMD
        |=> st_ff.cnt == $past(st_ff.cnt) + 5'h01 || st_ff.cnt == spitrp_pkg::CNT_RST)
        else $error("header bit count did not step");
    // First header bit is the direction flag
    dir_capture_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_rise && st_ff.state == spitrp_pkg::SPITRP_ST_CMD
        && st_ff.cnt == spitrp_pkg::CNT_RST |=> st_ff.is_wr == $past(sdi_s))
        else $error("direction flag not captured");
    // Deselect drops the command and quiets the output
    cmd_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sel_n_s |=> !st_ff.is_wr && !sdo)
        else $error("command state kept over deselect");
    // Write data phase returns zeros on the output
    wr_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_fall && st_ff.state == spitrp_pkg::SPITRP_ST_WR |=> !sdo)
        else $error("output not low during write data");
    // Read data leaves MSB first, one bit per falling clock
    rd_shift_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_fall && st_ff.state == spitrp_pkg::SPITRP_ST_RD |=> sdo == $past(st_ff.shreg[7]))
        else $error("read bit out of order");
    // Fetched byte lands in the shift register when no edge competes
    rd_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        st_ff.fetch && !sel_n_s && !sclk_fall && st_ff.state == spitrp_pkg::SPITRP_ST_RD
        |=> st_ff.shreg == $past(rd_byte))
        else $error("fetched byte not loaded");
    // End of a read byte moves to the next address and fetches it
    rd_incr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_fall && st_ff.state == spitrp_pkg::SPITRP_ST_RD
        && st_ff.cnt[2:0] == spitrp_pkg::BIT_LAST
        |=> st_ff.addr == $past(st_ff.addr) + 15'h0001 ##1 st_ff.fetch)
        else $error("read address not advanced");
    // Eighth data bit of a write issues one store request with that byte
    wr_store_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        sclk_rise && st_ff.state == spitrp_pkg::SPITRP_ST_WR
        && st_ff.cnt[2:0] == spitrp_pkg::BIT_LAST
        |=> st_ff.wreq.en && st_ff.wreq.data == {$past(st_ff.shreg[6:0]), $past(sdi_s)})
        else $error("write byte not issued");
    // A stalled clock leaves address, data and phase untouched
    stall_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !sel_n_s && !sclk_rise && !sclk_fall && !st_ff.fetch
        |=> $stable(st_ff.addr) && $stable(st_ff.shreg) && $stable(st_ff.state))
        else $error("frame moved while clock stalled");
    // Status reports an accepted write
    ram_hit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_in_ram |=> st_ff.status == 8'h01)
        else $error("status missed accepted write");
    // A read header leaves no store request behind
    rd_nowrite_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        st_ff.state == spitrp_pkg::SPITRP_ST_RD |-> !st_ff.wreq.en)
        else $error("store request during a read");
endmodule : spitrp_top
